// ### verilog/rfpll_regs.sv
// Control registers for the reference monitor and fractional loop.
// Assumes a single-cycle software port; reads answer one cycle later.
`timescale 1ns/100ps
`default_nettype none
`include "rfpll_defines.svh"
module rfpll_regs
  import rfpll_pkg::*;
(
  input wire logic core_clk, // Clock, 100 MHz
  input wire logic rst, // Async reset, active high
  input wire logic [`RFPLL_ADDR_W-1:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata_q, // Read data, cycle after rd
  output logic mon_en_q, // Monitor active
  output logic mon_freq_q, // 0 25 MHz, 1 19.44 MHz inputs
  output logic mon_low_rate_q, // 8 kHz reference mode
  output logic [1:0] mon_carr_q, // Effective carrier code
  output logic [1:0] mon_tol_q, // Tolerance code
  output logic cal_start_q, // One-cycle calibration pulse
  output logic div_sync_q, // Hold loop dividers in sync
  output logic loop_pd_q, // Loop power-down
  output logic loop_rst_q, // Loop reset
  output logic dbl_en_q, // Doubler path select
  output logic [1:0] loop_mode_q, // Feedback path select
  output logic sdm_pd_q, // Sigma-delta power-down
  output logic [7:0] cp_code_q, // Pump current, 4 uA per step
  output logic [1:0] pole2_q // Pole-2 resistor code
);
  logic [7:0] mon_r;
  logic [7:0] ctrl_r;
  logic [7:0] path_r;
  logic [7:0] cp_r;
  logic [7:0] lf_r;
  logic cal_pulse;
  logic [7:0] rd_d;
  logic wr_mon;
  logic wr_ctrl;
  logic wr_path;
  logic wr_cp;
  logic wr_lf;
  logic addr_mapped;
  logic cal_rise_wr;

  // Reset images; output flops start where their register starts
  localparam logic [7:0] MON_RST = `RFPLL_R_MON;
  localparam logic [7:0] CTRL_RST = `RFPLL_R_CTRL;
  localparam logic [7:0] PATH_RST = `RFPLL_R_PATH;
  localparam logic [7:0] CP_RST = `RFPLL_R_CP;
  localparam logic [7:0] LF_RST = `RFPLL_R_LF;

  // ==========================================================
  // Address decode, shared by storage and checks
  assign wr_mon = wr && (addr == `RFPLL_A_MON);
  assign wr_ctrl = wr && (addr == `RFPLL_A_CTRL);
  assign wr_path = wr && (addr == `RFPLL_A_PATH);
  assign wr_cp = wr && (addr == `RFPLL_A_CP);
  assign wr_lf = wr && (addr == `RFPLL_A_LF);
  assign addr_mapped = (addr == `RFPLL_A_MON) || (addr == `RFPLL_A_CTRL) ||
                       (addr == `RFPLL_A_PATH) || (addr == `RFPLL_A_CP) ||
                       (addr == `RFPLL_A_LF);
  // A write that raises the stored calibration bit
  assign cal_rise_wr = wr_ctrl && wdata[`RFPLL_B_CAL] &&
                       !ctrl_r[`RFPLL_B_CAL];

  // ==========================================================
  // Register storage
  rfpll_reg8 #(.RST_VAL(`RFPLL_R_MON), .WR_MASK(`RFPLL_M_MON)) u_mon (
    .core_clk(core_clk), .rst(rst),
    .wr_en(wr_mon),
    .wr_data(wdata), .val_q(mon_r)
  );
  rfpll_reg8 #(.RST_VAL(`RFPLL_R_CTRL), .WR_MASK(`RFPLL_M_CTRL)) u_ctrl (
    .core_clk(core_clk), .rst(rst),
    .wr_en(wr_ctrl),
    .wr_data(wdata), .val_q(ctrl_r)
  );
  rfpll_reg8 #(.RST_VAL(`RFPLL_R_PATH), .WR_MASK(`RFPLL_M_PATH)) u_path (
    .core_clk(core_clk), .rst(rst),
    .wr_en(wr_path),
    .wr_data(wdata), .val_q(path_r)
  );
  rfpll_reg8 #(.RST_VAL(`RFPLL_R_CP), .WR_MASK(`RFPLL_M_CP)) u_cp (
    .core_clk(core_clk), .rst(rst),
    .wr_en(wr_cp),
    .wr_data(wdata), .val_q(cp_r)
  );
  // Only the pole-2 field lives here; other filter fields are elsewhere
  rfpll_reg8 #(.RST_VAL(`RFPLL_R_LF), .WR_MASK(`RFPLL_M_LF)) u_lf (
    .core_clk(core_clk), .rst(rst),
    .wr_en(wr_lf),
    .wr_data(wdata), .val_q(lf_r)
  );

  // ==========================================================
  // Calibration edge launcher
  rfpll_cal_pulse u_cal (
    .core_clk(core_clk), .rst(rst),
    .cal_bit(ctrl_r[`RFPLL_B_CAL]),
    .cal_start_q(cal_pulse)
  );

  // ==========================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    case (addr)
      `RFPLL_A_MON: rd_d = mon_r;
      `RFPLL_A_CTRL: rd_d = ctrl_r;
      `RFPLL_A_PATH: rd_d = path_r;
      `RFPLL_A_CP: rd_d = cp_r;
      `RFPLL_A_LF: rd_d = lf_r;
      default: rd_d = 8'h00;
    endcase
  end

  // Data valid only in the cycle after rd
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rd_d : 8'h00;
    end
  end

  // ==========================================================
  // Monitor controls, registered again so outputs come from flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mon_en_q <= MON_RST[`RFPLL_B_MON_EN];
      mon_freq_q <= MON_RST[`RFPLL_B_MON_FREQ];
      mon_low_rate_q <= MON_RST[`RFPLL_B_MON_LOW];
      mon_carr_q <= MON_RST[`RFPLL_F_CARR_HI:`RFPLL_F_CARR_LO];
      mon_tol_q <= MON_RST[`RFPLL_F_TOL_HI:`RFPLL_F_TOL_LO];
    end else begin
      mon_en_q <= mon_r[`RFPLL_B_MON_EN];
      mon_freq_q <= mon_r[`RFPLL_B_MON_FREQ];
      mon_low_rate_q <= mon_r[`RFPLL_B_MON_LOW];
      // Carrier code is masked while low rate overrides it
      mon_carr_q <= mon_r[`RFPLL_B_MON_LOW] ? 2'h0
                  : mon_r[`RFPLL_F_CARR_HI:`RFPLL_F_CARR_LO];
      mon_tol_q <= mon_r[`RFPLL_F_TOL_HI:`RFPLL_F_TOL_LO];
    end
  end

  // ==========================================================
  // Loop controls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cal_start_q <= 1'b0;
      div_sync_q <= CTRL_RST[`RFPLL_B_SYNC];
      loop_pd_q <= CTRL_RST[`RFPLL_B_PD];
      loop_rst_q <= CTRL_RST[`RFPLL_B_RST];
    end else begin
      cal_start_q <= cal_pulse;
      div_sync_q <= ctrl_r[`RFPLL_B_SYNC];
      loop_pd_q <= ctrl_r[`RFPLL_B_PD];
      loop_rst_q <= ctrl_r[`RFPLL_B_RST];
    end
  end

  // Path and filter; reserved loop mode passes through, analog ignores it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dbl_en_q <= PATH_RST[`RFPLL_B_DBL];
      loop_mode_q <= PATH_RST[`RFPLL_F_MODE_HI:`RFPLL_F_MODE_LO];
      sdm_pd_q <= PATH_RST[`RFPLL_B_SDM_PD];
      cp_code_q <= CP_RST;
      pole2_q <= LF_RST[`RFPLL_F_POLE_HI:`RFPLL_F_POLE_LO];
    end else begin
      dbl_en_q <= path_r[`RFPLL_B_DBL];
      loop_mode_q <= path_r[`RFPLL_F_MODE_HI:`RFPLL_F_MODE_LO];
      sdm_pd_q <= path_r[`RFPLL_B_SDM_PD];
      cp_code_q <= cp_r;
      pole2_q <= lf_r[`RFPLL_F_POLE_HI:`RFPLL_F_POLE_LO];
    end
  end

  // ==========================================================
  // Checks
  property p_mon_en;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_MON) |=> ##1 (mon_en_q == $past(wdata[7], 2));
  endproperty
  a_mon_en: assert property (p_mon_en) else $error("mon enable");

  property p_freq;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_MON) |=> ##1 (mon_freq_q == $past(wdata[5], 2));
  endproperty
  a_freq: assert property (p_freq) else $error("mon freq");

  property p_low_override;
    @(posedge core_clk) disable iff (rst)
    mon_low_rate_q |-> mon_carr_q == 2'h0;
  endproperty
  a_low_override: assert property (p_low_override) else $error("carr");

  property p_carr;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_MON && !wdata[4]) |=> ##1
      (mon_carr_q == $past(wdata[3:2], 2));
  endproperty
  a_carr: assert property (p_carr) else $error("carrier code");

  property p_tol;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_MON) |=> ##1 (mon_tol_q == $past(wdata[1:0], 2));
  endproperty
  a_tol: assert property (p_tol) else $error("tolerance");

  property p_cal_rise;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_CTRL && wdata[3] && !ctrl_r[3]) |=> ##2
      cal_start_q;
  endproperty
  a_cal_rise: assert property (p_cal_rise) else $error("no cal");

  property p_sync;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_CTRL) |=> ##1 (div_sync_q == $past(wdata[2], 2));
  endproperty
  a_sync: assert property (p_sync) else $error("sync");

  property p_pd_rst;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_CTRL) |=> ##1
      (loop_pd_q == $past(wdata[1], 2) && loop_rst_q == $past(wdata[0], 2));
  endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("pd or reset");

  property p_path;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_PATH) |=> ##1
      ({dbl_en_q, loop_mode_q, sdm_pd_q} == $past(wdata[3:0], 2));
  endproperty
  a_path: assert property (p_path) else $error("path");

  property p_cp;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_CP) |=> ##1 (cp_code_q == $past(wdata, 2));
  endproperty
  a_cp: assert property (p_cp) else $error("pump");

  property p_pole;
    @(posedge core_clk) disable iff (rst)
    (wr && addr == `RFPLL_A_LF) |=> ##1 (pole2_q == $past(wdata[7:6], 2));
  endproperty
  a_pole: assert property (p_pole) else $error("pole2");

  property p_rsvd;
    @(posedge core_clk) disable iff (rst)
    rd && addr == `RFPLL_A_CTRL |=> rdata_q[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved");

  property p_rsvd_mon;
    @(posedge core_clk) disable iff (rst)
    rd && addr == `RFPLL_A_MON |=> (rdata_q & ~`RFPLL_M_MON) == 8'h00;
  endproperty
  a_rsvd_mon: assert property (p_rsvd_mon) else $error("mon rsvd");

  property p_rsvd_path;
    @(posedge core_clk) disable iff (rst)
    rd && addr == `RFPLL_A_PATH |=> (rdata_q & ~`RFPLL_M_PATH) == 8'h00;
  endproperty
  a_rsvd_path: assert property (p_rsvd_path) else $error("path rsvd");

  property p_rsvd_lf;
    @(posedge core_clk) disable iff (rst)
    rd && addr == `RFPLL_A_LF |=> (rdata_q & ~`RFPLL_M_LF) == 8'h00;
  endproperty
  a_rsvd_lf: assert property (p_rsvd_lf) else $error("filter rsvd");

  // Unmapped space reads as zero
  property p_unmap_rd;
    @(posedge core_clk) disable iff (rst)
    rd && !addr_mapped |=> rdata_q == 8'h00;
  endproperty
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped rd");

  // Read data only stand in the cycle after a strobe
  property p_rd_idle;
    @(posedge core_clk) disable iff (rst)
    !rd |=> rdata_q == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rd idle");

  // A stray write must not alias onto any register
  property p_stray_wr;
    @(posedge core_clk) disable iff (rst)
    wr && !addr_mapped |=> $stable(mon_r) && $stable(ctrl_r) &&
      $stable(path_r) && $stable(cp_r) && $stable(lf_r);
  endproperty
  a_stray_wr: assert property (p_stray_wr) else $error("stray");

  // No calibration pulse without a rising write three edges earlier
  property p_cal_only;
    @(posedge core_clk) disable iff (rst)
    cal_start_q |-> $past(cal_rise_wr, 3);
  endproperty
  a_cal_only: assert property (p_cal_only) else $error("spurious cal");

  property p_cal_hold;
    @(posedge core_clk) disable iff (rst)
    (wr_ctrl && wdata[`RFPLL_B_CAL] && ctrl_r[`RFPLL_B_CAL]) |=> ##2
      !cal_start_q;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("cal on hold");

  // Level outputs move only after a write to their register
  property p_mon_hold;
    @(posedge core_clk) disable iff (rst)
    !wr_mon |=> ##1 $stable({mon_en_q, mon_freq_q, mon_low_rate_q,
      mon_carr_q, mon_tol_q});
  endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("mon drift");

  property p_ctrl_hold;
    @(posedge core_clk) disable iff (rst)
    !wr_ctrl |=> ##1
      $stable({div_sync_q, loop_pd_q, loop_rst_q});
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl drift");

  property p_path_hold;
    @(posedge core_clk) disable iff (rst)
    !wr_path |=> ##1
      $stable({dbl_en_q, loop_mode_q, sdm_pd_q});
  endproperty
  a_path_hold: assert property (p_path_hold) else $error("path drift");

  property p_cp_hold;
    @(posedge core_clk) disable iff (rst)
    !wr_cp |=> ##1 $stable(cp_code_q);
  endproperty
  a_cp_hold: assert property (p_cp_hold) else $error("pump drift");

  property p_pole_hold;
    @(posedge core_clk) disable iff (rst)
    !wr_lf |=> ##1 $stable(pole2_q);
  endproperty
  a_pole_hold: assert property (p_pole_hold) else $error("pole drift");

  property p_carr_low;
    @(posedge core_clk) disable iff (rst)
    (wr_mon && wdata[`RFPLL_B_MON_LOW]) |=> ##1
      (mon_low_rate_q && mon_carr_q == 2'h0);
  endproperty
  a_carr_low: assert property (p_carr_low) else $error("low rate");

  c_cal: cover property (@(posedge core_clk) cal_start_q);
  c_low: cover property (@(posedge core_clk) mon_low_rate_q && mon_en_q);
  c_mode: cover property (@(posedge core_clk) loop_mode_q == 2'h2);
  c_stray: cover property (@(posedge core_clk) wr && !addr_mapped);
  c_wr_rd: cover property (@(posedge core_clk) wr_mon ##1 rd);
endmodule : rfpll_regs
`default_nettype wire

// ### shared/rfpll_defines.svh
// Constants for the reference monitor and fractional loop control registers.
// Assumes inclusion by bare name from design and bench files.
`ifndef RFPLL_DEFINES_SVH
`define RFPLL_DEFINES_SVH

// ==========================================================
// Register addresses
`define RFPLL_ADDR_W 12
`define RFPLL_A_MON 12'h083
`define RFPLL_A_CTRL 12'h100
`define RFPLL_A_PATH 12'h101
`define RFPLL_A_CP 12'h102
`define RFPLL_A_LF 12'h103

// ==========================================================
// Writable masks and reset values
`define RFPLL_M_MON 8'hBF
`define RFPLL_M_CTRL 8'h0F
`define RFPLL_M_PATH 8'h0F
`define RFPLL_M_CP 8'hFF
`define RFPLL_M_LF 8'hC0
`define RFPLL_R_MON 8'h00
`define RFPLL_R_CTRL 8'h00
`define RFPLL_R_PATH 8'h01
`define RFPLL_R_CP 8'h8D
`define RFPLL_R_LF 8'hC0

// ==========================================================
// Field positions
`define RFPLL_B_MON_EN 7
`define RFPLL_B_MON_FREQ 5
`define RFPLL_B_MON_LOW 4
`define RFPLL_F_CARR_HI 3
`define RFPLL_F_CARR_LO 2
`define RFPLL_F_TOL_HI 1
`define RFPLL_F_TOL_LO 0
`define RFPLL_B_CAL 3
`define RFPLL_B_SYNC 2
`define RFPLL_B_PD 1
`define RFPLL_B_RST 0
`define RFPLL_B_DBL 3
`define RFPLL_F_MODE_HI 2
`define RFPLL_F_MODE_LO 1
`define RFPLL_B_SDM_PD 0
`define RFPLL_F_POLE_HI 7
`define RFPLL_F_POLE_LO 6
`define RFPLL_CP_UA_STEP 4

`endif

// ### shared/rfpll_pkg.sv
// Types for the reference monitor and fractional loop control registers.
// Assumes the defines header is on the include path.
package rfpll_pkg;
  // ==========================================================
  // Field encodings
  typedef enum logic [1:0] {
    RFPLL_CARR_10M = 2'h0,
    RFPLL_CARR_19M44 = 2'h1,
    RFPLL_CARR_25M = 2'h2,
    RFPLL_CARR_38M88 = 2'h3
  } rfpll_carr_t;
  typedef enum logic [1:0] {
    RFPLL_MODE_SINGLE = 2'h0,
    RFPLL_MODE_CASC = 2'h1,
    RFPLL_MODE_FIXDLY = 2'h2,
    RFPLL_MODE_RSVD = 2'h3
  } rfpll_mode_t;
  typedef enum logic [1:0] {
    RFPLL_CAL_IDLE = 2'h0,
    RFPLL_CAL_FIRE = 2'h1
  } rfpll_cal_st_t;
endpackage : rfpll_pkg

// ### verilog/rfpll_reg8.sv
// One 8-bit control register with a write mask.
// Assumes write strobe already qualified by address decode.
`timescale 1ns/100ps
`default_nettype none
module rfpll_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic wr_en, // Write this register
  input wire logic [7:0] wr_data, // Write data
  output logic [7:0] val_q // Stored value
);
  // ==========================================================
  // Storage; reserved bits stay at reset value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      val_q <= RST_VAL;
    end else if (wr_en) begin
      val_q <= (wr_data & WR_MASK) | (RST_VAL & ~WR_MASK);
    end
  end
endmodule : rfpll_reg8
`default_nettype wire

// ### verilog/rfpll_cal_pulse.sv
// Calibration launcher: one pulse per low-to-high of the calibration bit.
// Assumes the bit is a registered control level.
`timescale 1ns/100ps
`default_nettype none
module rfpll_cal_pulse
  import rfpll_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic cal_bit, // Calibration control level
  output logic cal_start_q // One-cycle start pulse
);
  rfpll_cal_st_t st_q;
  rfpll_cal_st_t st_d;
  logic prev_q;

  // ==========================================================
  // Previous level for edge detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= cal_bit;
    end
  end

  // Fire only on a fresh rise; a held bit does nothing more
  always_comb begin
    case (st_q)
      RFPLL_CAL_IDLE: st_d = (cal_bit && !prev_q) ? RFPLL_CAL_FIRE
                                                  : RFPLL_CAL_IDLE;
      RFPLL_CAL_FIRE: st_d = RFPLL_CAL_IDLE;
      default: st_d = RFPLL_CAL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= RFPLL_CAL_IDLE;
      cal_start_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cal_start_q <= (st_d == RFPLL_CAL_FIRE);
    end
  end

  // ==========================================================
  // Checks
  property p_cal_once;
    @(posedge core_clk) disable iff (rst)
    cal_start_q |=> !cal_start_q;
  endproperty
  a_cal_once: assert property (p_cal_once) else $error("cal pulse long");
endmodule : rfpll_cal_pulse
`default_nettype wire

// ### dv/rfpll_regs_tb.sv
// Self-checking bench for the monitor and fractional loop control registers.
// Assumes the defines header is on the include path; one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "rfpll_defines.svh"
module rfpll_regs_tb
  import rfpll_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic core_clk;
  logic rst;
  logic [`RFPLL_ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata_q;
  logic mon_en_q, mon_freq_q, mon_low_rate_q, cal_start_q, div_sync_q;
  logic loop_pd_q, loop_rst_q, dbl_en_q, sdm_pd_q;
  logic [1:0] mon_carr_q, mon_tol_q, loop_mode_q, pole2_q;
  logic [7:0] cp_code_q;
  int err_total = 0;
  int checks_done = 0;

  rfpll_regs dut (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .mon_en_q(mon_en_q),
    .mon_freq_q(mon_freq_q), .mon_low_rate_q(mon_low_rate_q),
    .mon_carr_q(mon_carr_q), .mon_tol_q(mon_tol_q),
    .cal_start_q(cal_start_q), .div_sync_q(div_sync_q),
    .loop_pd_q(loop_pd_q), .loop_rst_q(loop_rst_q), .dbl_en_q(dbl_en_q),
    .loop_mode_q(loop_mode_q), .sdm_pd_q(sdm_pd_q),
    .cp_code_q(cp_code_q), .pole2_q(pole2_q)
  );

  // ==========================================================
  // Clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Shared helpers
  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Write, then wait two edges so the field outputs have settled
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [11:0] a,
                        input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(name, rdata_q, exp);
    @(posedge core_clk);
    #1;
    chk("rd_idle", rdata_q, 8'h00);
  endtask : rd_chk

  function automatic logic [7:0] mon_out();
    return {mon_en_q, 1'b0, mon_freq_q, mon_low_rate_q, mon_carr_q,
            mon_tol_q};
  endfunction : mon_out

  // ==========================================================
  // Scenarios
  task automatic t_reset_and_unmapped();
    chk("rst_sdm", {7'h00, sdm_pd_q}, 8'h01);
    chk("rst_cp", cp_code_q, 8'h8D);
    chk("rst_loop", {1'b0, cal_start_q, div_sync_q, loop_pd_q,
        loop_rst_q, dbl_en_q, loop_mode_q}, 8'h00);
    chk("rst_rdata", rdata_q, 8'h00);
    chk("rst_pole2", {6'h00, pole2_q}, 8'h03);
    chk("rst_mon", mon_out(), 8'h00);
    // Stray writes must not alias onto a mapped register
    wr_reg(12'h084, 8'hFF);
    wr_reg(12'h000, 8'hFF);
    rd_chk("unmapped", 12'h084, 8'h00);
    rd_chk("rd_mon", `RFPLL_A_MON, 8'h00);
    rd_chk("rd_ctrl", `RFPLL_A_CTRL, 8'h00);
    rd_chk("rd_path", `RFPLL_A_PATH, 8'h01);
    rd_chk("rd_cp", `RFPLL_A_CP, 8'h8D);
    rd_chk("rd_lf", `RFPLL_A_LF, 8'hC0);
  endtask : t_reset_and_unmapped

  task automatic t_monitor();
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {2'b10, i[0], 1'b0, i[3:0]};
      // Monitor enabled first; switchover setup lives outside this block
      wr_reg(`RFPLL_A_MON, v | 8'h40);
      chk("mon_fields", mon_out(), v);
      rd_chk("mon_rd", `RFPLL_A_MON, v);
    end
    // Low rate hides the carrier code but keeps it stored
    wr_reg(`RFPLL_A_MON, 8'h1E);
    chk("mon_low", mon_out(), 8'h12);
    rd_chk("mon_low_rd", `RFPLL_A_MON, 8'h1E);
    // Enabled monitor in low-rate mode, reserved bit written high
    wr_reg(`RFPLL_A_MON, 8'hFE);
    chk("mon_low_en", mon_out(), 8'hB2);
    rd_chk("mon_low_en_rd", `RFPLL_A_MON, 8'hBE);
  endtask : t_monitor

  task automatic cal_w(input logic [7:0] d, input logic pulse);
    @(posedge core_clk);
    addr <= `RFPLL_A_CTRL;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    for (int i = 1; i < 6; i++) begin
      #1;
      chk("cal_start", {7'h00, cal_start_q}, {7'h00, pulse && i == 3});
      @(posedge core_clk);
    end
  endtask : cal_w

  task automatic t_control();
    for (int k = 0; k < 3; k++) begin
      wr_reg(`RFPLL_A_CTRL, 8'h01 << k);
      chk("ctrl_lvl", {5'h00, div_sync_q, loop_pd_q, loop_rst_q},
          8'h01 << k);
    end
    cal_w(8'h08, 1'b1);
    cal_w(8'h08, 1'b0);
    cal_w(8'h00, 1'b0);
    cal_w(8'hF8, 1'b1);
    rd_chk("ctrl_rd", `RFPLL_A_CTRL, 8'h08);
  endtask : t_control

  task automatic t_path();
    for (int i = 0; i < 16; i++) begin
      wr_reg(`RFPLL_A_PATH, {4'hF, i[3:0]});
      chk("path", {4'h0, dbl_en_q, loop_mode_q, sdm_pd_q},
          {4'h0, i[3:0]});
      rd_chk("path_rd", `RFPLL_A_PATH, {4'h0, i[3:0]});
    end
  endtask : t_path

  task automatic t_pump_pole();
    logic [7:0] cp [3] = '{8'h00, 8'hFF, 8'h3C};
    foreach (cp[j]) begin
      wr_reg(`RFPLL_A_CP, cp[j]);
      chk("cp_code", cp_code_q, cp[j]);
      rd_chk("cp_rd", `RFPLL_A_CP, cp[j]);
    end
    for (int p = 0; p < 4; p++) begin
      wr_reg(`RFPLL_A_LF, {p[1:0], 6'h3F});
      chk("pole2", {6'h00, pole2_q}, {6'h00, p[1:0]});
      rd_chk("lf_rd", `RFPLL_A_LF, {p[1:0], 6'h00});
    end
  endtask : t_pump_pole

  // ==========================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Main sequence needs well under 2000 cycles
  initial begin
    rst = 1'b1;
    addr = '0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset_and_unmapped();
    t_monitor();
    t_control();
    t_path();
    t_pump_pole();
    give_verdict();
  end

  // Watchdog so a stuck run still ends with a verdict
  initial begin
    repeat (2000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end
endmodule : rfpll_regs_tb
`default_nettype wire
